// ---- verilog/prot_ind_pkg.sv ----
// constants, encodings and register map of the protection indicator block
package prot_ind_pkg;

  // system clock
  localparam longint unsigned CLK_HZ = 200_000_000;

  // times in milliseconds
  localparam longint unsigned FOV_DELAY_MS = 10_000;
  localparam longint unsigned GOV_DELAY_MS = 750;
  localparam longint unsigned REPLAY_MS = 5_000;
  localparam longint unsigned FLASH_HALF_MS = 250;
  localparam longint unsigned SECOND_MS = 1_000;

  // times in clock cycles
  localparam longint unsigned FOV_CYC = FOV_DELAY_MS * CLK_HZ / 1000;
  localparam longint unsigned GOV_CYC = GOV_DELAY_MS * CLK_HZ / 1000;
  localparam longint unsigned REPLAY_CYC = REPLAY_MS * CLK_HZ / 1000;
  localparam longint unsigned FLASH_CYC = FLASH_HALF_MS * CLK_HZ / 1000;
  localparam longint unsigned SECOND_CYC = SECOND_MS * CLK_HZ / 1000;

  // shutdown cause codes, also the nonvolatile record
  typedef enum logic [2:0] {
    CAUSE_NONE = 3'h0,
    CAUSE_FOV = 3'h1,
    CAUSE_GOV = 3'h2,
    CAUSE_LOS = 3'h3,
    CAUSE_OEL = 3'h4,
    CAUSE_UEL = 3'h5
  } cause_t;

  // power-up phases
  typedef enum logic [1:0] {
    ST_BOOT = 2'h0,
    ST_REPLAY = 2'h1,
    ST_RUN = 2'h2
  } phase_t;

  // indicator positions
  localparam int N_LED = 9;
  localparam int LED_FOV = 0;
  localparam int LED_GOV = 1;
  localparam int LED_LOS = 2;
  localparam int LED_OEL = 3;
  localparam int LED_UEL = 4;
  localparam int LED_VARPF = 5;
  localparam int LED_MANUAL = 6;
  localparam int LED_UNDERFREQ = 7;
  localparam int LED_EXCLIM = 8;

  // register byte addresses
  localparam logic [7:0] REG_CONFIG = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CAUSE = 8'h08;

  // config fields
  localparam int CFG_FOV_EN = 0;
  localparam int CFG_HW_SD_EN = 1;
  localparam int CFG_LOS_MANUAL = 2;
  localparam int CFG_VARPF_EN = 3;
  localparam int CFG_MANUAL_EN = 4;
  localparam int CFG_OEL_DLY_LSB = 8;
  localparam int CFG_UEL_DLY_LSB = 12;
  localparam int DLY_W = 4;
  localparam logic [31:0] CONFIG_RST = 32'h0000_0001;

  // status fields
  localparam int STS_SHUT = 9;
  localparam int STS_CONTACT = 10;
  localparam int STS_MANUAL = 11;
  localparam int STS_PHASE_LSB = 12;

  // cause register fields
  localparam int CSE_LIVE_LSB = 0;
  localparam int CSE_REPLAY_LSB = 4;

endpackage : prot_ind_pkg

// ---- verilog/prot_ind.sv ----
// protection and status indicator logic of the excitation regulator
`timescale 1ns/1ps

// Contract
// - nine indicators, each from its own condition
// - field overvoltage held 10 s lights indicator
// - qualified overexcitation asserts shutdown
// - replay overexcitation shutdown steady for 5 s
// - generator overvoltage held 0.75 s lights indicator
// - generator overvoltage closes contacts; optional shutdown
// - replay generator overvoltage steady for 5 s
// - sensing loss lights indicator, closes contacts
// - sensing loss: shutdown or transfer to manual
// - replay sensing loss flashing for 5 s
// - overexcitation limiting lit until clear or shutdown
// - replay overexcitation limiting flashing for 5 s
// - underexcitation lit until clear or shutdown
// - replay underexcitation flashing for 5 s
// - var/pf indicator: enabled and contact open
// - manual indicator while manual mode operates
// - underfrequency indicator: below setpoint on curve
// - excitation limiting lit only while condition
module prot_ind #(
  parameter logic [31:0] T_FOV = 32'(prot_ind_pkg::FOV_CYC),
  parameter logic [31:0] T_GOV = 32'(prot_ind_pkg::GOV_CYC),
  parameter logic [31:0] T_REPLAY = 32'(prot_ind_pkg::REPLAY_CYC),
  parameter logic [31:0] T_FLASH = 32'(prot_ind_pkg::FLASH_CYC),
  parameter logic [31:0] T_SECOND = 32'(prot_ind_pkg::SECOND_CYC)
) (
  // clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // register port
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR_EN,
  input wire logic RD_EN,
  output logic [31:0] RDATA,
  // sensing and mode flags
  input wire logic FIELD_OV_FLAG,
  input wire logic GEN_OV_FLAG,
  input wire logic SENSE_LOSS_FLAG,
  input wire logic OEL_FLAG,
  input wire logic UEL_FLAG,
  input wire logic EXC_LIM_FLAG,
  input wire logic UNDERFREQ_FLAG,
  input wire logic VHZ_ACTIVE,
  input wire logic VAR_PF_SELECT_CONTACT,
  // nonvolatile cause store
  input wire prot_ind_pkg::cause_t NV_CAUSE_IN,
  output prot_ind_pkg::cause_t NV_CAUSE,
  output logic NV_WR,
  // panel and plant outputs
  output logic [8:0] LED,
  output logic OUT_CONTACT,
  output logic SHUTDOWN,
  output logic MANUAL_MODE
);
  import prot_ind_pkg::*;

  typedef struct packed {
    phase_t phase;
    logic [31:0] rep_cnt;
    cause_t rep_cause;
    logic [31:0] flash_cnt;
    logic flash;
    logic [31:0] fov_cnt;
    logic [31:0] gov_cnt;
    logic [31:0] oel_cyc;
    logic [DLY_W-1:0] oel_sec;
    logic [31:0] uel_cyc;
    logic [DLY_W-1:0] uel_sec;
    logic shut;
    cause_t cause;
    logic manual_xfer;
    logic [31:0] cfg;
    logic [N_LED-1:0] led;
    logic contact;
    logic manual;
    logic nv_wr;
    logic [31:0] rdata;
  } state_t;

  state_t s;
  state_t next_s;

  // one-second tick and seconds count of a limiter delay
  function automatic logic [DLY_W+31:0] lim_step(
    input logic flag,
    input logic [DLY_W-1:0] sec,
    input logic [31:0] cyc
  );
    logic [DLY_W-1:0] nsec;
    logic [31:0] ncyc;
    nsec = sec;
    ncyc = cyc;
    if (!flag) begin
      nsec = '0;
      ncyc = '0;
    end else if (cyc == T_SECOND - 32'h1) begin
      ncyc = '0;
      if (sec != {DLY_W{1'b1}}) begin
        nsec = sec + {{(DLY_W-1){1'b0}}, 1'b1};
      end
    end else begin
      ncyc = cyc + 32'h1;
    end
    return {nsec, ncyc};
  endfunction : lim_step

  // indicator pattern replayed for a stored cause
  function automatic logic [N_LED-1:0] replay_mask(input cause_t c, input logic fl);
    logic [N_LED-1:0] m;
    m = '0;
    case (c)
      CAUSE_FOV: m[LED_FOV] = 1'b1;
      CAUSE_GOV: m[LED_GOV] = 1'b1;
      CAUSE_LOS: m[LED_LOS] = fl;
      CAUSE_OEL: m[LED_OEL] = fl;
      CAUSE_UEL: m[LED_UEL] = fl;
      default: m = '0;
    endcase
    return m;
  endfunction : replay_mask

  logic live;
  logic fov_on;
  logic fov_q;
  logic gov_q;
  logic oel_exp;
  logic uel_exp;
  logic los_sd;
  logic manual_act;
  cause_t sd_cause;
  logic [N_LED-1:0] led_live;

  always_comb begin
    next_s = s;
    next_s.nv_wr = 1'b0;
    next_s.rdata = '0;
    live = (s.phase != ST_BOOT);

    // power-up phases
    case (s.phase)
      ST_BOOT: begin
        next_s.rep_cause = NV_CAUSE_IN;
        next_s.rep_cnt = '0;
        next_s.phase = (NV_CAUSE_IN == CAUSE_NONE) ? ST_RUN : ST_REPLAY;
      end
      ST_REPLAY: begin
        next_s.rep_cnt = s.rep_cnt + 32'h1;
        if (s.rep_cnt == T_REPLAY - 32'h1) begin
          next_s.phase = ST_RUN;
        end
      end
      ST_RUN: next_s.phase = ST_RUN;
      default: next_s.phase = ST_BOOT;
    endcase

    // flash timebase
    if (s.flash_cnt == T_FLASH - 32'h1) begin
      next_s.flash_cnt = '0;
      next_s.flash = ~s.flash;
    end else begin
      next_s.flash_cnt = s.flash_cnt + 32'h1;
    end

    // field overvoltage qualification
    fov_on = live && s.cfg[CFG_FOV_EN] && FIELD_OV_FLAG;
    fov_q = fov_on && (s.fov_cnt == T_FOV);
    if (!fov_on) begin
      next_s.fov_cnt = '0;
    end else if (s.fov_cnt != T_FOV) begin
      next_s.fov_cnt = s.fov_cnt + 32'h1;
    end

    // generator overvoltage qualification
    gov_q = live && GEN_OV_FLAG && (s.gov_cnt == T_GOV);
    if (!(live && GEN_OV_FLAG)) begin
      next_s.gov_cnt = '0;
    end else if (s.gov_cnt != T_GOV) begin
      next_s.gov_cnt = s.gov_cnt + 32'h1;
    end

    // limiter alarm delays in whole seconds
    {next_s.oel_sec, next_s.oel_cyc} = lim_step(live && OEL_FLAG, s.oel_sec, s.oel_cyc);
    {next_s.uel_sec, next_s.uel_cyc} = lim_step(live && UEL_FLAG, s.uel_sec, s.uel_cyc);
    oel_exp = live && OEL_FLAG && (s.oel_sec >= s.cfg[CFG_OEL_DLY_LSB +: DLY_W]);
    uel_exp = live && UEL_FLAG && (s.uel_sec >= s.cfg[CFG_UEL_DLY_LSB +: DLY_W]);

    // sensing loss action
    los_sd = live && SENSE_LOSS_FLAG && !s.cfg[CFG_LOS_MANUAL];
    if (live && SENSE_LOSS_FLAG && s.cfg[CFG_LOS_MANUAL]) begin
      next_s.manual_xfer = 1'b1;
    end
    manual_act = s.cfg[CFG_MANUAL_EN] || s.manual_xfer;

    // shutdown arbitration, first cause wins and is stored
    if (fov_q) begin
      sd_cause = CAUSE_FOV;
    end else if (gov_q && s.cfg[CFG_HW_SD_EN]) begin
      sd_cause = CAUSE_GOV;
    end else if (los_sd) begin
      sd_cause = CAUSE_LOS;
    end else if (oel_exp) begin
      sd_cause = CAUSE_OEL;
    end else if (uel_exp) begin
      sd_cause = CAUSE_UEL;
    end else begin
      sd_cause = CAUSE_NONE;
    end
    if (!s.shut && sd_cause != CAUSE_NONE) begin
      next_s.shut = 1'b1;
      next_s.cause = sd_cause;
      next_s.nv_wr = 1'b1;
    end

    // live indicators
    led_live = '0;
    if (live) begin
      led_live[LED_FOV] = fov_q || (s.shut && s.cause == CAUSE_FOV);
      led_live[LED_GOV] = gov_q;
      led_live[LED_LOS] = SENSE_LOSS_FLAG;
      led_live[LED_OEL] = OEL_FLAG && !s.shut;
      led_live[LED_UEL] = UEL_FLAG && !s.shut;
      led_live[LED_VARPF] = s.cfg[CFG_VARPF_EN] && !VAR_PF_SELECT_CONTACT;
      led_live[LED_MANUAL] = manual_act;
      led_live[LED_UNDERFREQ] = UNDERFREQ_FLAG && VHZ_ACTIVE;
      led_live[LED_EXCLIM] = EXC_LIM_FLAG;
    end
    next_s.led = led_live;
    if (s.phase == ST_REPLAY) begin
      next_s.led = led_live | replay_mask(s.rep_cause, s.flash);
    end
    next_s.contact = gov_q || (live && SENSE_LOSS_FLAG);
    next_s.manual = manual_act;

    // register port
    if (WR_EN && ADDR == REG_CONFIG) begin
      next_s.cfg = WDATA;
    end
    if (RD_EN) begin
      case (ADDR)
        REG_CONFIG: next_s.rdata = s.cfg;
        REG_STATUS: begin
          next_s.rdata[N_LED-1:0] = s.led;
          next_s.rdata[STS_SHUT] = s.shut;
          next_s.rdata[STS_CONTACT] = s.contact;
          next_s.rdata[STS_MANUAL] = s.manual;
          next_s.rdata[STS_PHASE_LSB +: 2] = s.phase;
        end
        REG_CAUSE: begin
          next_s.rdata[CSE_LIVE_LSB +: 3] = s.cause;
          next_s.rdata[CSE_REPLAY_LSB +: 3] = s.rep_cause;
        end
        default: next_s.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      s <= '0;
      s.cfg <= CONFIG_RST;
    end else begin
      s <= next_s;
    end
  end

  assign RDATA = s.rdata;
  assign LED = s.led;
  assign OUT_CONTACT = s.contact;
  assign SHUTDOWN = s.shut;
  assign MANUAL_MODE = s.manual;
  assign NV_WR = s.nv_wr;
  assign NV_CAUSE = s.cause;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  sequence fov_ready_s;
    s.phase != ST_BOOT && s.cfg[CFG_FOV_EN] && FIELD_OV_FLAG && s.fov_cnt == T_FOV;
  endsequence

  sequence shut_latched_s;
    SHUTDOWN && NV_WR ##1 SHUTDOWN && !NV_WR;
  endsequence

  fov_shutdown_a: assert property (fov_ready_s |=> LED[LED_FOV] && SHUTDOWN)
    else $error("field overvoltage did not light indicator and shut down");

  shut_record_a: assert property ($rose(SHUTDOWN) |-> shut_latched_s)
    else $error("shutdown cause not written once to storage");

  shut_hold_a: assert property (SHUTDOWN |=> SHUTDOWN && $stable(NV_CAUSE))
    else $error("shutdown or its cause dropped");

  gov_contact_a: assert property (
    s.phase != ST_BOOT && GEN_OV_FLAG && s.gov_cnt == T_GOV |=> OUT_CONTACT && LED[LED_GOV])
    else $error("generator overvoltage did not close contacts");

  gov_early_a: assert property (
    $rose(LED[LED_GOV]) && $past(s.phase) != ST_REPLAY |-> $past(s.gov_cnt) == T_GOV)
    else $error("generator overvoltage indicator lit before delay");

  los_action_a: assert property (
    s.phase != ST_BOOT && SENSE_LOSS_FLAG && s.cfg[CFG_LOS_MANUAL]
    |=> LED[LED_LOS] && OUT_CONTACT ##1 MANUAL_MODE)
    else $error("sensing loss did not transfer to manual");

  exc_follow_a: assert property (
    s.phase != ST_BOOT ##1 1'b1 |-> LED[LED_EXCLIM] == $past(EXC_LIM_FLAG))
    else $error("excitation limiting indicator does not follow condition");

  varpf_led_a: assert property (
    s.phase != ST_BOOT ##1 1'b1
    |-> LED[LED_VARPF] == ($past(s.cfg[CFG_VARPF_EN]) && !$past(VAR_PF_SELECT_CONTACT)))
    else $error("var/pf indicator wrong");

  replay_bound_a: assert property (s.phase == ST_REPLAY |-> s.rep_cnt < T_REPLAY)
    else $error("replay ran past its time");

  status_read_a: assert property (RD_EN && ADDR == REG_STATUS |=> RDATA[8:0] == $past(LED))
    else $error("status read does not show indicators");

  los_shutdown_a: assert property (
    s.phase != ST_BOOT && SENSE_LOSS_FLAG && !s.cfg[CFG_LOS_MANUAL] |=> SHUTDOWN)
    else $error("sensing loss did not shut down");

  los_contact_a: assert property (
    s.phase != ST_BOOT && SENSE_LOSS_FLAG |=> LED[LED_LOS] && OUT_CONTACT)
    else $error("sensing loss did not light indicator or close contacts");

  // limiter indicators only checked outside replay, where no mask is added
  oel_led_a: assert property (
    s.phase == ST_RUN ##1 1'b1 |-> LED[LED_OEL] == ($past(OEL_FLAG) && !$past(SHUTDOWN)))
    else $error("overexcitation limiting indicator wrong");

  uel_led_a: assert property (
    s.phase == ST_RUN ##1 1'b1 |-> LED[LED_UEL] == ($past(UEL_FLAG) && !$past(SHUTDOWN)))
    else $error("underexcitation indicator wrong");

  underfreq_led_a: assert property (
    s.phase != ST_BOOT ##1 1'b1
    |-> LED[LED_UNDERFREQ] == ($past(UNDERFREQ_FLAG) && $past(VHZ_ACTIVE)))
    else $error("underfrequency indicator wrong");

  manual_led_a: assert property (
    s.phase != ST_BOOT ##1 1'b1 |-> LED[LED_MANUAL] == MANUAL_MODE)
    else $error("manual indicator does not match manual mode");

  sequence oel_due_s;
    s.phase != ST_BOOT && OEL_FLAG && s.oel_sec >= s.cfg[CFG_OEL_DLY_LSB +: DLY_W];
  endsequence

  sequence uel_due_s;
    s.phase != ST_BOOT && UEL_FLAG && s.uel_sec >= s.cfg[CFG_UEL_DLY_LSB +: DLY_W];
  endsequence

  oel_shutdown_a: assert property (oel_due_s |=> SHUTDOWN)
    else $error("overexcitation delay expired without shutdown");

  uel_shutdown_a: assert property (uel_due_s |=> SHUTDOWN)
    else $error("underexcitation delay expired without shutdown");

  gov_sd_option_a: assert property (
    $rose(SHUTDOWN) && NV_CAUSE == CAUSE_GOV |-> $past(s.cfg[CFG_HW_SD_EN]))
    else $error("generator overvoltage shut down with option off");

  replay_fov_a: assert property (
    s.phase == ST_REPLAY && s.rep_cause == CAUSE_FOV |=> LED[LED_FOV])
    else $error("overexcitation shutdown replay not steady");

  replay_gov_a: assert property (
    s.phase == ST_REPLAY && s.rep_cause == CAUSE_GOV |=> LED[LED_GOV])
    else $error("generator overvoltage replay not steady");

  replay_flash_a: assert property (
    s.phase == ST_REPLAY && s.rep_cause == CAUSE_LOS ##1 1'b1
    |-> LED[LED_LOS] == ($past(s.flash) || $past(SENSE_LOSS_FLAG)))
    else $error("sensing loss replay does not follow flash timebase");

endmodule : prot_ind

// ---- dv/nv_store_model.sv ----
// nonvolatile shutdown cause store beside the indicator block
`timescale 1ns/1ps
module nv_store_model
  import prot_ind_pkg::*;
(
  // clock and store port
  input wire logic clk,
  input wire logic wr,
  input wire cause_t d,
  output cause_t q
);
  initial q = CAUSE_NONE;
  // keeps its content across the block's reset
  always @(posedge clk) begin
    if (wr) begin
      q <= d;
    end
  end
endmodule : nv_store_model

// ---- dv/testbench.sv ----
// self-checking bench of the protection indicator block
`timescale 1ns/1ps
module testbench;
  import prot_ind_pkg::*;
  logic clk, sys_rst, wr_en, rd_en;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  logic fov, gov, los, exc, uf, vhz, vpc, nv_wr;
  logic [1:0] lim;
  logic [8:0] led;
  logic contact, shut, manual;
  cause_t nv_in, nv_out;
  int bad_count, n_compared;

  prot_ind #(.T_FOV(32'h14), .T_GOV(32'h8), .T_REPLAY(32'h28), .T_FLASH(32'h3),
    .T_SECOND(32'h5)) prot_ind_i (
    .CLK(clk), .SYS_RST(sys_rst), .ADDR(addr), .WDATA(wdata), .WR_EN(wr_en), .RD_EN(rd_en),
    .RDATA(rdata), .FIELD_OV_FLAG(fov), .GEN_OV_FLAG(gov), .SENSE_LOSS_FLAG(los),
    .OEL_FLAG(lim[0]), .UEL_FLAG(lim[1]), .EXC_LIM_FLAG(exc), .UNDERFREQ_FLAG(uf),
    .VHZ_ACTIVE(vhz), .VAR_PF_SELECT_CONTACT(vpc), .NV_CAUSE_IN(nv_in), .NV_CAUSE(nv_out),
    .NV_WR(nv_wr), .LED(led), .OUT_CONTACT(contact), .SHUTDOWN(shut), .MANUAL_MODE(manual));
  nv_store_model nv_store_model_i (.clk(clk), .wr(nv_wr), .d(nv_out), .q(nv_in));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic conclude;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : rd

  task automatic rst;
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    tick(3);
  endtask : rst

  // power cycle, then watch the replayed indicator: steady or flashing
  task automatic replay(input int b, input bit fl);
    int on;
    int tg;
    logic prev;
    rst();
    on = 0;
    tg = 0;
    prev = led[b];
    repeat (30) begin
      tick(1);
      on += int'(led[b] === 1'b1);
      tg += int'(led[b] !== prev);
      prev = led[b];
    end
    if (fl) begin
      chk(32'(tg > 5), 32'h1);
    end else begin
      chk(32'(on), 32'h1e);
    end
    tick(20);
    chk(32'(led[b]), 32'h0);
    $display("replay of indicator %0d done", b);
  endtask : replay

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    $display("ERROR t=%0t watchdog expired", $time);
    conclude();
  end

  initial begin
    sys_rst = 1'b1;
    {fov, gov, los, exc, uf, vhz, vpc, wr_en, rd_en} = '0;
    lim = 2'h0;
    addr = 8'h0;
    wdata = 32'h0;
    rst();
    rd(REG_CONFIG, CONFIG_RST);
    rd(8'h0c, 32'h0);
    wr(8'h0c, 32'hffff_ffff);
    rd(8'h0c, 32'h0);
    wr(REG_CONFIG, 32'h0000_ff18);
    rd(REG_CONFIG, 32'h0000_ff18);
    $display("registers done");
    @(posedge clk);
    {exc, uf, vhz, lim} <= 5'h1f;
    tick(3);
    chk(32'(led), 32'h1f8);
    @(posedge clk);
    {exc, vhz, lim, vpc} <= 5'h01;
    tick(3);
    chk(32'(led), 32'h040);
    chk(32'(shut), 32'h0);
    $display("indicators done");
    rst();
    @(posedge clk);
    gov <= 1'b1;
    tick(8);
    chk(32'(led[1]), 32'h0);
    tick(4);
    chk(32'({led[1], contact, shut}), 32'h6);
    @(posedge clk);
    gov <= 1'b0;
    tick(3);
    chk(32'(led[1]), 32'h0);
    wr(REG_CONFIG, 32'h3);
    @(posedge clk);
    gov <= 1'b1;
    tick(12);
    chk(32'({shut, nv_in}), 32'ha);
    rd(REG_STATUS, 32'h0000_2602);
    rd(REG_CAUSE, 32'h0000_0002);
    @(posedge clk);
    gov <= 1'b0;
    replay(1, 1'b0);
    @(posedge clk);
    fov <= 1'b1;
    tick(19);
    chk(32'({led[0], shut}), 32'h0);
    tick(6);
    chk(32'({led[0], shut, nv_in}), 32'h19);
    @(posedge clk);
    fov <= 1'b0;
    tick(3);
    chk(32'(led[0]), 32'h1);
    replay(0, 1'b0);
    wr(REG_CONFIG, 32'h5);
    @(posedge clk);
    los <= 1'b1;
    tick(5);
    chk(32'({led[2], contact, manual, shut}), 32'he);
    @(posedge clk);
    los <= 1'b0;
    rst();
    @(posedge clk);
    los <= 1'b1;
    tick(4);
    chk(32'({shut, nv_in}), 32'hb);
    @(posedge clk);
    los <= 1'b0;
    replay(2, 1'b1);
    for (int k = 0; k < 2; k++) begin
      wr(REG_CONFIG, 32'h1 | (32'h1 << (8 + 4 * k)));
      @(posedge clk);
      lim[k] <= 1'b1;
      tick(3);
      chk(32'({led[3 + k], shut}), 32'h2);
      tick(8);
      chk(32'({led[3 + k], shut, nv_in}), 32'h0c + 32'(k));
      @(posedge clk);
      lim[k] <= 1'b0;
      replay(3 + k, 1'b1);
    end
    conclude();
  end
endmodule : testbench
